// ---- core/csi_fwd_engine.sv ----
// Purpose: forwards packets from four video buffers onto one CSI-2 link
// Assumes: buffers share core_clk_i; the CSI-2 lane logic runs on link_clk_i
// Notes:   line-concatenated selection behaves as basic synchronized here
// Functional notes
// RL1 - pull buffer packets, deliver to transmitter output
// RL2 - drive LP/HS transitions, emit sync packets
// RL3 - watch every buffer for packet availability
// RL4 - per-port disable bit blocks forwarding
// RL5 - upper nibble maps buffers to transmitter
// RL6 - each engine configured independently
// RL7 - round robin streams split by VC/DT
// RL8 - round robin serves pending ports as available
// RL9 - round robin forwards every FS/FE separately
// RL10 - round robin bit enables best effort mode
// RL11 - synchronized modes send ports 0 to 3
// RL12 - sources aligned within one line period
// RL13 - sources share identical video parameters
// RL14 - on sync failure discard until frame start
// RL15 - synced status and read-cleared lost flag
// RL16 - mode field selects synchronized variant
// RL17 - software clears RR, disables, then sets mode
// RL18 - basic mode sends full frame per source
// RL19 - basic mode keeps each port's VC
// RL20 - interleave keeps one FS/FE per frame
// RL21 - interleave sends every line as packet
// RL22 - interleave sources share one VC, unchecked
// RL23 - read only fully buffered packets
// RL24 - synced status zero when sync disabled
// RL25 - round robin pointer moves past served port
`include "fwd_engine_map.svh"
module csi_fwd_engine
  import fwd_engine_pkg::*;
#(
  parameter int NPORT           = 4,
  parameter int SYNC_WIN_CYCLES = `SYNC_WIN_CYC
) (
  input  wire logic                  core_clk_i,   // engine clock
  input  wire logic                  arst_n_i,     // async reset
  input  wire logic                  link_clk_i,   // CSI-2 lane clock
  input  wire logic [7:0]            reg_addr_i,   // register offset
  input  wire logic                  reg_wr_i,     // write strobe
  input  wire logic [7:0]            reg_wdata_i,  // write data
  input  wire logic                  reg_rd_i,     // read strobe
  output logic      [7:0]            reg_rdata_o,  // read data
  input  wire logic [NPORT-1:0]      buf_avail_i,  // whole packet at head
  input  wire logic [NPORT-1:0][1:0] buf_kind_i,   // head packet kind
  input  wire logic [NPORT-1:0][1:0] buf_vc_i,     // head packet VC
  input  wire logic [NPORT-1:0][5:0] buf_dt_i,     // head packet DT
  input  wire logic [NPORT-1:0][7:0] buf_data_i,   // current byte
  input  wire logic [NPORT-1:0]      buf_last_i,   // current byte is last
  output logic      [NPORT-1:0]      buf_pop_o,    // take current byte
  output logic                       tx_hs_o,      // lanes in HS mode
  output logic                       tx_valid_o,   // word offered
  input  wire logic                  tx_ready_i,   // word accepted
  output logic                       tx_sop_o,     // first word of packet
  output logic                       tx_eop_o,     // last word of packet
  output logic      [1:0]            tx_kind_o,    // packet kind
  output logic      [1:0]            tx_vc_o,      // virtual channel
  output logic      [5:0]            tx_dt_o,      // data type
  output logic      [7:0]            tx_data_o     // payload byte
);
  localparam logic [15:0] WIN_LIM = 16'(SYNC_WIN_CYCLES);
  core_state_t     c_q;           // core-domain state
  core_state_t     c_d;
  link_state_reg_t l_q;           // link-domain state
  link_state_reg_t l_d;
  logic       ack_sync;           // link ack toggle, in core domain
  logic       req_sync;           // core req toggle, in link domain
  logic [NPORT-1:0] active;       // ports this engine forwards
  logic       rr_on;              // best-effort mode live
  logic       sync_on;            // synchronized mode live
  sync_mode_t smode;              // selected synchronized variant
  logic       free;               // link has taken the last word
  logic [1:0] first_act;          // lowest active port
  logic       any_act;            // at least one active port
  logic       all_fs;             // every active port holds a frame start
  logic [1:0] nxt_act;            // next active port after expected one
  logic       wrap;               // expected port is the last active one
  // crossings of the two handshake toggles
  sync_2ff #(.W(1)) u_ack_sync (
    .clk_i    (core_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (l_q.ack_tgl),
    .q_o      (ack_sync)
  );
  sync_2ff #(.W(1)) u_req_sync (
    .clk_i    (link_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (c_q.req_tgl),
    .q_o      (req_sync)
  );

  // decode of the control registers and port scan
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      // mapped to this transmitter and not disabled
      active[p] = ~c_q.port_ctl[`PORT_DIS_LSB + p] // RL4
                & ~c_q.port_ctl[`PORT_MAP_LSB + p]; // RL5
    end
    smode   = sync_mode_t'(c_q.mode_ctl[`SYNC_MODE_LSB +: 2]); // RL16
    sync_on = (smode != SM_OFF);
    rr_on   = c_q.mode_ctl[`RR_EN_BIT] & ~sync_on; // RL10
    free    = (ack_sync == c_q.req_tgl);
    any_act = |active;
    // lowest active port starts every round
    first_act = 2'h0;
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (active[p]) begin
        first_act = 2'(p);
      end
    end
    // frame start waiting on every active port
    all_fs = any_act;
    for (int p = 0; p < NPORT; p++) begin
      if (active[p] && !(buf_avail_i[p] &&
          pkt_kind_t'(buf_kind_i[p]) == KIND_FS)) begin
        all_fs = 1'b0;
      end
    end
    // next active port above the expected one, ascending order
    nxt_act = first_act;
    wrap    = 1'b1;
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (active[p] && 2'(p) > c_q.exp_port) begin
        nxt_act = 2'(p); // RL11
        wrap    = 1'b0;
      end
    end
  end

  // core-domain next state: registers, arbitration and packet pulls
  always_comb begin
    logic       hit;          // a port was chosen this cycle
    logic       ok;           // head packet fits the sync sequence
    logic       fail;         // synchronization lost this cycle
    logic       others;       // some other active port is waiting
    logic [1:0] idx;          // port under consideration
    pkt_kind_t  k;            // kind at the expected port
    hit    = 1'b0;
    ok     = 1'b0;
    fail   = 1'b0;
    others = 1'b0;
    idx    = 2'h0;
    k      = KIND_OTHER;
    c_d       = c_q;
    buf_pop_o = '0;

    case (c_q.st)
      ST_IDLE: begin
        if (rr_on) begin
          // search from the pointer for a full packet
          for (int i = 0; i < NPORT; i++) begin
            idx = 2'(c_q.rr_ptr + 2'(i));
            if (!hit && active[idx] && buf_avail_i[idx]) begin // RL3 RL23
              hit          = 1'b1;
              c_d.cur_port = idx; // RL8
              c_d.rr_ptr   = 2'(idx + 2'h1); // RL25
            end
          end
          if (hit) begin
            // any kind goes out, frame packets of each VC included
            c_d.st    = ST_SEND; // RL7 RL9
            c_d.first = 1'b1;
          end
        end else if (sync_on && !c_q.synced) begin
          if (all_fs) begin
            // every source at frame start: restart in step
            c_d.synced   = 1'b1; // RL14
            c_d.phase    = KIND_FS;
            c_d.exp_port = first_act;
            c_d.wait_cnt = '0;
          end else begin
            // discard anything short of a frame start
            for (int p = NPORT - 1; p >= 0; p--) begin
              if (active[p] && buf_avail_i[p] &&
                  pkt_kind_t'(buf_kind_i[p]) != KIND_FS) begin
                hit          = 1'b1;
                c_d.cur_port = 2'(p);
              end
            end
            if (hit) begin
              c_d.st = ST_DROP; // RL14
            end
          end
        end else if (sync_on) begin
          idx = c_q.exp_port;
          k   = pkt_kind_t'(buf_kind_i[idx]);
          for (int p = 0; p < NPORT; p++) begin
            if (active[p] && buf_avail_i[p] && 2'(p) != idx) begin
              others = 1'b1;
            end
          end
          if (!active[idx]) begin
            // port set changed under us: resync
            fail = 1'b1;
          end else if (buf_avail_i[idx]) begin // RL23
            case (c_q.phase)
              KIND_FS:   ok = (k == KIND_FS);
              KIND_LINE: ok = (k == KIND_LINE) ||
                              (k == KIND_FE && idx == first_act);
              default:   ok = (k == KIND_FE);
            endcase
            if (ok) begin
              c_d.cur_port = idx;
              c_d.first    = 1'b1;
              c_d.wait_cnt = '0;
              // interleave passes frame packets of lowest port only
              if (smode == SM_INTERLEAVE && k != KIND_LINE &&
                  idx != first_act) begin
                c_d.st = ST_DROP; // RL20
              end else begin
                c_d.st = ST_SEND; // RL18 RL21
              end
              // step to the next port, next round at the wrap
              c_d.exp_port = nxt_act; // RL11
              if (k == KIND_FE && c_q.phase == KIND_LINE) begin
                c_d.phase = KIND_FE;
              end
              if (wrap) begin
                c_d.phase = (k == KIND_FE) ? KIND_FS : KIND_LINE;
              end
            end else begin
              fail = 1'b1;
            end
          end else if (others) begin
            // others are ahead: the late source has one window
            if (c_q.wait_cnt >= WIN_LIM) begin
              fail = 1'b1;
            end else begin
              c_d.wait_cnt = c_q.wait_cnt + 16'h1;
            end
          end
        end
      end
      ST_SEND: begin
        // one byte per finished handshake
        if (free) begin
          idx              = c_q.cur_port;
          c_d.word.sop     = c_q.first;
          c_d.word.eop     = buf_last_i[idx];
          c_d.word.kind    = pkt_kind_t'(buf_kind_i[idx]);
          c_d.word.vc      = buf_vc_i[idx]; // RL19
          c_d.word.dt      = buf_dt_i[idx];
          c_d.word.data    = buf_data_i[idx];
          c_d.req_tgl      = ~c_q.req_tgl; // RL1
          c_d.first        = 1'b0;
          buf_pop_o[idx]   = 1'b1;
          if (buf_last_i[idx]) begin
            c_d.st = ST_IDLE;
          end
        end
      end
      ST_DROP: begin
        // discard the packet byte by byte
        buf_pop_o[c_q.cur_port] = 1'b1;
        if (buf_last_i[c_q.cur_port]) begin
          c_d.st = ST_IDLE;
        end
      end
      default: begin
        c_d.st = ST_IDLE;
      end
    endcase
    // out of step or sync off: stop and wait for the next frame start
    if (fail || !sync_on) begin
      c_d.synced   = 1'b0; // RL14
      c_d.wait_cnt = '0;
    end
    // register writes, this engine's own control pair
    if (reg_wr_i) begin // RL6
      if (reg_addr_i == `FWD_PORT_CTL_OFS) begin
        c_d.port_ctl = reg_wdata_i;
      end else if (reg_addr_i == `FWD_MODE_CTL_OFS) begin
        c_d.mode_ctl = reg_wdata_i;
      end
    end
    // register reads, data held until the next read
    if (reg_rd_i) begin
      if (reg_addr_i == `FWD_PORT_CTL_OFS) begin
        c_d.rdata = c_q.port_ctl;
      end else if (reg_addr_i == `FWD_MODE_CTL_OFS) begin
        c_d.rdata = c_q.mode_ctl;
      end else if (reg_addr_i == `FWD_STATUS_OFS) begin
        c_d.rdata = 8'h00;
        c_d.rdata[`STAT_SYNCED_BIT] = c_q.synced & sync_on; // RL24 RL15
        c_d.rdata[`STAT_LOST_BIT]   = c_q.lost;
        c_d.lost                    = 1'b0; // RL15
      end else begin
        c_d.rdata = 8'h00;
      end
    end
    // a loss in the read cycle still sticks
    if (fail && c_q.synced) begin
      c_d.lost = 1'b1; // RL15
    end
  end

  // core-domain registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_q          <= '0;
      c_q.st       <= ST_IDLE;
      c_q.port_ctl <= `FWD_PORT_CTL_RST;
      c_q.mode_ctl <= `FWD_MODE_CTL_RST;
      c_q.phase    <= KIND_FS;
    end else begin
      c_q <= c_d;
    end
  end
  assign reg_rdata_o = c_q.rdata;
  // link-domain next state: lane mode and word hand-off
  always_comb begin
    l_d = l_q;
    // a new word is stable once its toggle has crossed
    if (req_sync != l_q.req_seen && !l_q.valid) begin
      l_d.word     = c_q.word;
      l_d.valid    = 1'b1;
      l_d.req_seen = req_sync;
    end
    case (l_q.st)
      LK_LP: begin
        // leave low power on the first word of a packet
        if (l_q.valid && l_q.word.sop) begin
          l_d.st = LK_PREP; // RL2
        end
      end
      LK_PREP: begin
        l_d.st = LK_HS; // RL2
      end
      LK_HS: begin
        if (l_q.valid && tx_ready_i) begin
          l_d.valid   = 1'b0;
          l_d.ack_tgl = ~l_q.ack_tgl;
          if (l_q.word.eop) begin
            l_d.st = LK_LP; // RL2
          end
        end
      end
      default: begin
        l_d.st = LK_LP;
      end
    endcase
  end
  // link-domain registers
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      l_q    <= '0;
      l_q.st <= LK_LP;
    end else begin
      l_q <= l_d;
    end
  end
  // lane outputs from link flops, HS and valid decoded from the lane state
  assign tx_hs_o    = (l_q.st != LK_LP);
  assign tx_valid_o = (l_q.st == LK_HS) & l_q.valid;
  assign tx_sop_o   = l_q.word.sop;
  assign tx_eop_o   = l_q.word.eop;
  assign tx_kind_o  = l_q.word.kind;
  assign tx_vc_o    = l_q.word.vc;
  assign tx_dt_o    = l_q.word.dt;
  assign tx_data_o  = l_q.word.data;

endmodule : csi_fwd_engine

// ---- core/fwd_engine_map.svh ----
// Purpose: register offsets, field positions, reset values and timing
// Assumes: included by bare name by the forwarding engine module
// Notes:   definitions only
`ifndef FWD_ENGINE_MAP_SVH
`define FWD_ENGINE_MAP_SVH

// register offsets on the register port
`define FWD_PORT_CTL_OFS   8'h20
`define FWD_MODE_CTL_OFS   8'h21
`define FWD_STATUS_OFS     8'h35

// forward_port_control fields
`define PORT_DIS_LSB       0
`define PORT_MAP_LSB       4

// forward_mode_control fields
`define RR_EN_BIT          0
`define SYNC_MODE_LSB      4

// status fields
`define STAT_SYNCED_BIT    0
`define STAT_LOST_BIT      1

// reset values: all ports enabled, mapped here, round robin on
`define FWD_PORT_CTL_RST   8'h00
`define FWD_MODE_CTL_RST   8'h01

// sync window: about one line period
`define CORE_CLK_MHZ       50
`define SYNC_WIN_US        30
`define SYNC_WIN_CYC       (`SYNC_WIN_US * `CORE_CLK_MHZ)

`endif

// ---- core/fwd_engine_pkg.sv ----
// Purpose: types shared by the forwarding engine
// Assumes: nothing
// Notes:   packet kinds are coded 0 to 3 in declaration order
package fwd_engine_pkg;

  // kind of packet at the head of a video buffer
  typedef enum logic [1:0] {KIND_FS, KIND_FE, KIND_LINE, KIND_OTHER}
    pkt_kind_t;

  // synchronized forwarding selection
  typedef enum logic [1:0] {SM_OFF, SM_BASIC, SM_INTERLEAVE, SM_CONCAT}
    sync_mode_t;

  // engine states in the core domain
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DROP} eng_state_t;

  // lane states in the link domain
  typedef enum logic [1:0] {LK_LP, LK_PREP, LK_HS} link_state_t;

  // one word handed across to the link side
  typedef struct packed {
    logic      sop;
    logic      eop;
    pkt_kind_t kind;
    logic [1:0] vc;
    logic [5:0] dt;
    logic [7:0] data;
  } xfer_word_t;

  // all core-domain state
  typedef struct packed {
    eng_state_t st;
    logic [7:0] port_ctl;
    logic [7:0] mode_ctl;
    logic [7:0] rdata;
    logic       lost;
    logic       synced;
    logic [1:0] rr_ptr;
    logic [1:0] cur_port;
    logic       first;
    logic [1:0] exp_port;
    pkt_kind_t  phase;
    logic [15:0] wait_cnt;
    xfer_word_t word;
    logic       req_tgl;
  } core_state_t;

  // all link-domain state
  typedef struct packed {
    link_state_t st;
    xfer_word_t  word;
    logic        valid;
    logic        req_seen;
    logic        ack_tgl;
  } link_state_reg_t;

endpackage : fwd_engine_pkg

// ---- core/sync_2ff.sv ----
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: input is a level that holds long enough to be seen
// Notes:   first stage is read only by the second stage
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // both stages of the chain
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // shift the chain
  always_comb begin
    s_d    = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.s2;

endmodule : sync_2ff

// ---- tb/csi_fwd_engine_properties.sv ----
// Purpose: port-level checks for the forwarding engine
// Assumes: control registers change only through the register port
// Notes:   shadow copies of the two control registers follow writes
module csi_fwd_engine_properties #(
  parameter int NPORT           = 4,
  parameter int SYNC_WIN_CYCLES = 20
) (
  input wire logic             core_clk_i,
  input wire logic             arst_n_i,
  input wire logic             link_clk_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic             reg_wr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [NPORT-1:0] buf_avail_i,
  input wire logic [NPORT-1:0] buf_pop_o,
  input wire logic             tx_hs_o,
  input wire logic             tx_valid_o,
  input wire logic             tx_ready_i,
  input wire logic             tx_sop_o,
  input wire logic             tx_eop_o,
  input wire logic [1:0]       tx_kind_o,
  input wire logic [1:0]       tx_vc_o,
  input wire logic [5:0]       tx_dt_o,
  input wire logic [7:0]       tx_data_o
);
  logic [7:0] port_q;  // shadow of forward_port_control
  logic [7:0] mode_q;  // shadow of forward_mode_control
  // follow software writes, reset values as the design
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_q <= 8'h00;
      mode_q <= 8'h01;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h20) port_q <= reg_wdata_i;
      if (reg_addr_i == 8'h21) mode_q <= reg_wdata_i;
    end
  end
  property p_pop_whole; @(posedge core_clk_i) disable iff (!arst_n_i)
    (buf_pop_o & ~buf_avail_i) == '0; endproperty
  a_pop_whole: assert property (p_pop_whole)
    else $error("pop, no packet");
  property p_pop_one; @(posedge core_clk_i) disable iff (!arst_n_i)
    $onehot0(buf_pop_o); endproperty
  a_pop_one: assert property (p_pop_one)
    else $error("two ports popped");
  property p_pop_block; @(posedge core_clk_i) disable iff (!arst_n_i)
    (buf_pop_o & (port_q[3:0] | port_q[7:4])) == '0; endproperty
  a_pop_block: assert property (p_pop_block)
    else $error("blocked pop");
  property p_idle_off; @(posedge core_clk_i) disable iff (!arst_n_i)
    mode_q[0] == 1'b0 && mode_q[5:4] == 2'h0 |-> buf_pop_o == '0; endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("pop with no mode");
  property p_rd_none; @(posedge core_clk_i) disable iff (!arst_n_i)
    reg_rd_i && !(reg_addr_i inside {8'h20, 8'h21, 8'h35})
    |=> reg_rdata_o == 8'h00; endproperty
  a_rd_none: assert property (p_rd_none)
    else $error("unmapped read");
  property p_sync_zero; @(posedge core_clk_i) disable iff (!arst_n_i)
    reg_rd_i && reg_addr_i == 8'h35 && mode_q[5:4] == 2'h0
    |=> !reg_rdata_o[0]; endproperty
  a_sync_zero: assert property (p_sync_zero)
    else $error("synced, off");
  property p_valid_hs; @(posedge link_clk_i) disable iff (!arst_n_i)
    tx_valid_o |-> tx_hs_o; endproperty
  a_valid_hs: assert property (p_valid_hs) else $error("word in LP");
  property p_word_hold; @(posedge link_clk_i) disable iff (!arst_n_i)
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_sop_o,
    tx_eop_o, tx_kind_o, tx_vc_o, tx_dt_o, tx_data_o}); endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word moved");
  property p_hs_end; @(posedge link_clk_i) disable iff (!arst_n_i)
    tx_valid_o && tx_ready_i && tx_eop_o |-> ##[1:2] !tx_hs_o; endproperty
  a_hs_end: assert property (p_hs_end) else $error("HS after end");
  // main scenarios reached
  c_eop: cover property (@(posedge link_clk_i) tx_valid_o && tx_eop_o);
  c_pop: cover property (@(posedge core_clk_i) buf_pop_o != '0);
  c_lost: cover property (@(posedge core_clk_i) reg_rdata_o[1]);
endmodule : csi_fwd_engine_properties

bind csi_fwd_engine csi_fwd_engine_properties #(.NPORT(NPORT),
  .SYNC_WIN_CYCLES(SYNC_WIN_CYCLES)) chk (.core_clk_i, .arst_n_i,
  .link_clk_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .buf_avail_i, .buf_pop_o, .tx_hs_o, .tx_valid_o, .tx_ready_i, .tx_sop_o,
  .tx_eop_o, .tx_kind_o, .tx_vc_o, .tx_dt_o, .tx_data_o);

// ---- tb/csi_fwd_engine_tb.sv ----
// Purpose: self-checking bench for the forwarding engine
// Assumes: bench stands in for the four video buffers
// Notes:   payload bytes carry port and index, second byte inverted
module csi_fwd_engine_tb
  import fwd_engine_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk_i = 0, link_clk_i = 0, arst_n_i = 0;
  logic [7:0]      reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic            reg_wr_i = 0, reg_rd_i = 0, slow = 0;
  logic [3:0]      buf_avail_i = 0, buf_last_i = 0, popped = 0, bi = 0;
  logic [3:0][1:0] buf_kind_i = 0, buf_vc_i = 0;
  logic [3:0][5:0] buf_dt_i = 0;
  logic [3:0][7:0] buf_data_i = 0;
  logic [3:0]      buf_pop_o;
  logic            tx_hs_o, tx_valid_o, tx_ready_i, tx_sop_o, tx_eop_o;
  logic [1:0]      tx_kind_o, tx_vc_o;
  logic [5:0]      tx_dt_o;
  logic [7:0]      tx_data_o;
  logic [17:0]     h;            // head packet being presented
  logic [17:0]     bq [4][$];    // buffer contents per port
  logic [25:0]     exp_q [$];    // packets expected on the link
  logic [1:0]      ks [3] = '{KIND_FS, KIND_LINE, KIND_FE};
  int              err_count = 0, comparisons = 0;
  always #10 core_clk_i = ~core_clk_i;
  initial begin
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  csi_fwd_engine #(.NPORT(4), .SYNC_WIN_CYCLES(20)) uut (.core_clk_i,
    .arst_n_i, .link_clk_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .buf_avail_i, .buf_kind_i, .buf_vc_i, .buf_dt_i,
    .buf_data_i, .buf_last_i, .buf_pop_o, .tx_hs_o, .tx_valid_o,
    .tx_ready_i, .tx_sop_o, .tx_eop_o, .tx_kind_o, .tx_vc_o, .tx_dt_o,
    .tx_data_o);
  csi_rx_model rx (.link_clk_i, .arst_n_i, .slow_i(slow),
    .valid_i(tx_valid_o), .sop_i(tx_sop_o), .eop_i(tx_eop_o),
    .kind_i(tx_kind_o), .vc_i(tx_vc_o), .dt_i(tx_dt_o),
    .data_i(tx_data_o), .ready_o(tx_ready_i));
  // buffers: note pops at the edge, present the next byte after it
  always @(posedge core_clk_i) popped <= buf_pop_o;
  always @(negedge core_clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (popped[p] && bq[p].size() > 0) begin
        if (bi[p]) void'(bq[p].pop_front());
        bi[p] = ~bi[p];
      end
      buf_avail_i[p] = bq[p].size() > 0;
      h = buf_avail_i[p] ? bq[p][0] : 18'h0;
      {buf_kind_i[p], buf_vc_i[p], buf_dt_i[p]} = h[17:8];
      buf_data_i[p] = bi[p] ? ~h[7:0] : h[7:0];
      buf_last_i[p] = bi[p];
    end
  end
  task stop_test;
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    check(reg_rdata_o, e);
  endtask : rd
  function automatic logic [17:0] pk(int p, logic [1:0] k, int v, int i);
    return {k, v[1:0], 6'h2B, p[1:0], i[5:0]};
  endfunction : pk
  task ld(input int p, input logic [1:0] k, input int v, input int i);
    bq[p].push_back(pk(p, k, v, i));
  endtask : ld
  task ex(input int p, input logic [1:0] k, input int v, input int i);
    exp_q.push_back({pk(p, k, v, i), ~p[1:0], ~i[5:0]});
  endtask : ex
  // wait for n packets, then compare them in order
  task drain(input int n);
    for (int i = 0; i < 4000 && rx.log_q.size() < n; i++)
      @(negedge core_clk_i);
    repeat (100) @(negedge core_clk_i);
    check(rx.log_q.size(), n);
    while (rx.log_q.size() > 0 && exp_q.size() > 0)
      check(rx.log_q.pop_front(), exp_q.pop_front());
    rx.log_q.delete();
    exp_q.delete();
  endtask : drain
  // hang guard
  initial begin
    #1_500_000;
    err_count++;
    stop_test;
  end
  // test sequence
  initial begin
    repeat (20) @(negedge core_clk_i);
    arst_n_i = 1;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h01);
    rd(8'h35, 8'h00);
    rd(8'h40, 8'h00);
    slow = 1;
    ld(1, KIND_LINE, 1, 0);
    ld(1, KIND_LINE, 1, 1);
    ld(3, KIND_LINE, 3, 0);
    ex(1, KIND_LINE, 1, 0);
    ex(3, KIND_LINE, 3, 0);
    ex(1, KIND_LINE, 1, 1);
    drain(3);
    slow = 0;
    wr(8'h20, 8'h42);
    for (int p = 0; p < 3; p++) ld(p, KIND_OTHER, p, 2);
    ex(0, KIND_OTHER, 0, 2);
    drain(1);
    check(bq[1].size() + bq[2].size(), 2);
    wr(8'h20, 8'h00);
    ex(1, KIND_OTHER, 1, 2);
    ex(2, KIND_OTHER, 2, 2);
    drain(2);
    wr(8'h21, 8'h00);
    ld(0, KIND_LINE, 0, 3);
    drain(0);
    check(bq[0].size(), 1);
    ex(0, KIND_LINE, 0, 3);
    wr(8'h21, 8'h01);
    drain(1);
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h10);
    slow = 1;
    for (int j = 0; j < 3; j++)
      for (int p = 0; p < 4; p++) begin
        ld(p, ks[j], p, j);
        ex(p, ks[j], p, j);
      end
    drain(12);
    rd(8'h35, 8'h01);
    for (int p = 1; p < 4; p++) ld(p, KIND_LINE, p, 4);
    drain(0);
    check(bq[1].size() + bq[2].size() + bq[3].size(), 0);
    rd(8'h35, 8'h02);
    rd(8'h35, 8'h00);
    wr(8'h21, 8'h20);
    for (int j = 0; j < 3; j++)
      for (int p = 0; p < 4; p++) begin
        ld(p, ks[j], 0, j);
        if (j == 1 || p == 0) ex(p, ks[j], 0, j);
      end
    drain(6);
    rd(8'h35, 8'h01);
    wr(8'h21, 8'h30);
    rd(8'h21, 8'h30);
    stop_test;
  end
endmodule : csi_fwd_engine_tb

// ---- tb/csi_rx_model.sv ----
// Purpose: CSI-2 receiver standing at the transmit link
// Assumes: two-byte packets, first word sop, second word eop
// Notes:   slow_i lets each word wait up to three link cycles
module csi_rx_model (
  input  wire logic       link_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       slow_i,
  input  wire logic       valid_i,
  input  wire logic       sop_i,
  input  wire logic       eop_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [1:0] vc_i,
  input  wire logic [5:0] dt_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  cnt_q;      // pacing counter
  logic [17:0] hdr_q;      // header and first byte
  logic [25:0] log_q [$];  // whole packets received
  // accept words, log each packet at its last word
  always @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q   <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      cnt_q   <= cnt_q + 2'h1;
      ready_o <= !slow_i || cnt_q == 2'h3;
      if (valid_i && ready_o && sop_i) hdr_q <= {kind_i, vc_i, dt_i, data_i};
      if (valid_i && ready_o && eop_i) log_q.push_back({hdr_q, data_i});
    end
  end
endmodule : csi_rx_model
